//--- src/wdg_top.sv
// Watchdog guard: control and restart registers, selectable counting clock,
// reset or NMI on time-out, sticky interrupt status with mask.
// Assumes ARST_N is every non-watchdog chip reset; RTC_CLK, RC_OSC_CLK and
// EXT_NMI are asynchronous pins, changing far slower than MCLK.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module wdg_top (
	// Clock and reset
	input wire logic MCLK,
	input wire logic ARST_N,
	// Register port
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// Counting clock pins
	input wire logic RTC_CLK,
	input wire logic RC_OSC_CLK,
	output logic RC_OSC_ON,
	// CPU side
	input wire logic EXT_NMI,
	output logic CPU_RST_REQ,
	output logic NMI_REQ,
	output logic IRQ
);
	import wdg_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers and rising edge detect
	// ----------------------------------------------------------------
	logic [2:0] pin_in;
	logic [2:0] pin_rise;

	assign pin_in = {EXT_NMI, RC_OSC_CLK, RTC_CLK};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			logic [SYNC_N-1:0] sync_q;
			always_ff @(posedge MCLK or negedge ARST_N) begin
				if (!ARST_N) begin
					sync_q <= '0;
				end else begin
					sync_q <= {sync_q[SYNC_N-2:0], pin_in[gi]};
				end
			end
			// Edge taken from second and third stages only
			assign pin_rise[gi] = sync_q[1] & ~sync_q[2];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic en_q;
	logic nmi_sel_q;
	logic rst_flag_q;
	logic nmi_flag_q;
	wdg_clk_t clk_sel_q;
	logic [1:0] per_q;
	wdg_key_t key_q;
	wdg_key_t key_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [IRQ_W-1:0] stat_q;
	logic [IRQ_W-1:0] mask_q;
	logic [7:0] rdata_q;
	logic cpu_rst_q;
	logic nmi_q;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire sel_ctl = (ADDR == ADDR_GUARD_CONTROL);
	wire sel_restart = (ADDR == ADDR_GUARD_RESTART);
	wire sel_stat = (ADDR == ADDR_IRQ_STATUS);
	wire sel_mask = (ADDR == ADDR_IRQ_MASK);

	wire wr_ctl = WR & sel_ctl & ~en_q;
	wire wr_restart = WR & sel_restart;
	wire wr_stat = WR & sel_stat;
	wire wr_mask = WR & sel_mask;

	// ----------------------------------------------------------------
	// Time-out length
	// ----------------------------------------------------------------
	function automatic logic [4:0] period_exp(input wdg_clk_t src, input logic [1:0] per);
		logic [4:0] e;
		e = 5'h00;
		case (src)
			WDG_CLK_SYS: begin
				case (per)
					2'b00: e = EXP_SYS_0;
					2'b01: e = EXP_SYS_1;
					2'b10: e = EXP_SYS_2;
					default: e = EXP_SYS_3;
				endcase
			end
			WDG_CLK_RTC: begin
				case (per)
					2'b00: e = EXP_RTC_0;
					2'b01: e = EXP_RTC_1;
					2'b10: e = EXP_RTC_2;
					default: e = EXP_RTC_3;
				endcase
			end
			WDG_CLK_RC: begin
				case (per)
					2'b00: e = EXP_RC_0;
					2'b01: e = EXP_RC_1;
					2'b10: e = EXP_RC_2;
					default: e = EXP_RC_3;
				endcase
			end
			default: e = 5'h00;
		endcase
		return e;
	endfunction

	wire [4:0] cur_exp = period_exp(clk_sel_q, per_q);
	wire [CNT_W:0] limit_full = ({{CNT_W{1'b0}}, 1'b1} << cur_exp) - {{CNT_W{1'b0}}, 1'b1};
	wire [CNT_W-1:0] limit_m1 = limit_full[CNT_W-1:0];

	// Counting tick from selected source; reserved code never ticks
	logic tick;
	always_comb begin
		case (clk_sel_q)
			WDG_CLK_SYS: tick = 1'b1;
			WDG_CLK_RTC: tick = pin_rise[0];
			WDG_CLK_RC: tick = pin_rise[1];
			default: tick = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Restart keys and expiry
	// ----------------------------------------------------------------
	wire key_ok = wr_restart & (key_q == WDG_KEY_ARMED) & (WDATA == KEY_SECOND);
	wire key_abort = wr_restart & (key_q == WDG_KEY_ARMED) & (WDATA != KEY_SECOND);
	wire expire = en_q & tick & (cnt_q == limit_m1) & ~key_ok;
	wire expire_rst = expire & ~nmi_sel_q;
	wire expire_nmi = expire & nmi_sel_q;

	always_comb begin
		key_d = key_q;
		case (key_q)
			WDG_KEY_IDLE: begin
				if (wr_restart && WDATA == KEY_FIRST) begin
					key_d = WDG_KEY_ARMED;
				end
			end
			WDG_KEY_ARMED: begin
				// Armed state survives any wait short of a reset time-out
				if (wr_restart) begin
					key_d = (WDATA == KEY_FIRST) ? WDG_KEY_ARMED : WDG_KEY_IDLE;
				end
			end
			default: key_d = WDG_KEY_IDLE;
		endcase
		if (expire_rst) begin
			key_d = WDG_KEY_IDLE;
		end
	end

	always_comb begin
		if (!en_q || key_ok || expire) begin
			cnt_d = CNT_RESET;
		end else if (tick) begin
			cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
		end else begin
			cnt_d = cnt_q;
		end
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			key_q <= WDG_KEY_IDLE;
			cnt_q <= CNT_RESET;
		end else begin
			key_q <= key_d;
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	// Watchdog reset reinitialises control but keeps the reset flag
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			en_q <= CTL_RESET[CTL_EN_BIT];
			nmi_sel_q <= CTL_RESET[CTL_NMI_SEL_BIT];
			clk_sel_q <= wdg_clk_t'(CTL_RESET[CTL_CLK_LSB+:2]);
			per_q <= CTL_RESET[CTL_PER_LSB+:2];
		end else if (expire_rst) begin
			en_q <= CTL_RESET[CTL_EN_BIT];
			nmi_sel_q <= CTL_RESET[CTL_NMI_SEL_BIT];
			clk_sel_q <= wdg_clk_t'(CTL_RESET[CTL_CLK_LSB+:2]);
			per_q <= CTL_RESET[CTL_PER_LSB+:2];
		end else if (wr_ctl) begin
			en_q <= WDATA[CTL_EN_BIT];
			nmi_sel_q <= WDATA[CTL_NMI_SEL_BIT];
			clk_sel_q <= wdg_clk_t'(WDATA[CTL_CLK_LSB+:2]);
			per_q <= WDATA[CTL_PER_LSB+:2];
		end
	end

	// Flags never take write data; set wins over clear
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_flag_q <= CTL_RESET[CTL_RST_FLAG_BIT];
			nmi_flag_q <= CTL_RESET[CTL_NMI_FLAG_BIT];
		end else begin
			rst_flag_q <= rst_flag_q | expire_rst;
			nmi_flag_q <= expire_nmi | (nmi_flag_q & ~pin_rise[2]);
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	wire [IRQ_W-1:0] irq_evt = {pin_rise[2], key_abort, expire};
	wire [IRQ_W-1:0] irq_clr = wr_stat ? WDATA[IRQ_W-1:0] : IRQ_STATUS_RESET;

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			stat_q <= IRQ_STATUS_RESET;
			mask_q <= IRQ_MASK_RESET;
		end else begin
			stat_q <= (stat_q & ~irq_clr) | irq_evt;
			if (wr_mask) begin
				mask_q <= WDATA[IRQ_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Read data and CPU outputs
	// ----------------------------------------------------------------
	wire [7:0] ctl_view = {en_q, nmi_sel_q, rst_flag_q, nmi_flag_q, clk_sel_q, per_q};
	logic [7:0] rd_mux;

	always_comb begin
		if (sel_ctl) begin
			rd_mux = ctl_view;
		end else if (sel_stat) begin
			rd_mux = {{(8-IRQ_W){1'b0}}, stat_q};
		end else if (sel_mask) begin
			rd_mux = {{(8-IRQ_W){1'b0}}, mask_q};
		end else begin
			// Restart register is write-only
			rd_mux = 8'h00;
		end
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rdata_q <= 8'h00;
			cpu_rst_q <= 1'b0;
			nmi_q <= 1'b0;
		end else begin
			rdata_q <= RD ? rd_mux : 8'h00;
			cpu_rst_q <= expire_rst;
			nmi_q <= expire_nmi;
		end
	end

	assign RDATA = rdata_q;
	assign CPU_RST_REQ = cpu_rst_q;
	assign NMI_REQ = nmi_q;
	assign IRQ = |(stat_q & mask_q);
	assign RC_OSC_ON = (clk_sel_q == WDG_CLK_RC);

endmodule

`default_nettype wire

//--- src/wdg_pkg.sv
// Package of the watchdog guard block: register map, field layout, reset values,
// clock source codes and time-out exponents.
// Assumes an 8-bit register port with byte addresses.
package wdg_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_GUARD_CONTROL = 8'h93;
	localparam logic [7:0] ADDR_GUARD_RESTART = 8'h94;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h95;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h96;

	// ----------------------------------------------------------------
	// Control field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTL_EN_BIT = 7;
	localparam int CTL_NMI_SEL_BIT = 6;
	localparam int CTL_RST_FLAG_BIT = 5;
	localparam int CTL_NMI_FLAG_BIT = 4;
	localparam int CTL_CLK_LSB = 2;
	localparam int CTL_PER_LSB = 0;
	localparam logic [7:0] CTL_RESET = 8'h08;

	// Restart keys
	localparam logic [7:0] KEY_FIRST = 8'hA5;
	localparam logic [7:0] KEY_SECOND = 8'h5A;

	// ----------------------------------------------------------------
	// Interrupt status bits and reset values
	// ----------------------------------------------------------------
	localparam int IRQ_W = 3;
	localparam int IRQ_TIMEOUT_BIT = 0;
	localparam int IRQ_KEY_ABORT_BIT = 1;
	localparam int IRQ_EXT_NMI_BIT = 2;
	localparam logic [IRQ_W-1:0] IRQ_STATUS_RESET = 3'h0;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

	// ----------------------------------------------------------------
	// Counter and synchroniser
	// ----------------------------------------------------------------
	localparam int CNT_W = 27;
	localparam logic [CNT_W-1:0] CNT_RESET = 27'h0;
	localparam int SYNC_N = 3;

	// ----------------------------------------------------------------
	// Clock source codes and time-out exponents (period = 2**exp cycles)
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		WDG_CLK_SYS = 2'b00,
		WDG_CLK_RTC = 2'b01,
		WDG_CLK_RC = 2'b10,
		WDG_CLK_RSV = 2'b11
	} wdg_clk_t;

	typedef enum logic {
		WDG_KEY_IDLE = 1'b0,
		WDG_KEY_ARMED = 1'b1
	} wdg_key_t;

	localparam logic [4:0] EXP_SYS_0 = 5'h1B;
	localparam logic [4:0] EXP_SYS_1 = 5'h19;
	localparam logic [4:0] EXP_SYS_2 = 5'h16;
	localparam logic [4:0] EXP_SYS_3 = 5'h12;
	localparam logic [4:0] EXP_RTC_0 = 5'h11;
	localparam logic [4:0] EXP_RTC_1 = 5'h0E;
	localparam logic [4:0] EXP_RTC_2 = 5'h0B;
	localparam logic [4:0] EXP_RTC_3 = 5'h07;
	localparam logic [4:0] EXP_RC_0 = 5'h0F;
	localparam logic [4:0] EXP_RC_1 = 5'h0D;
	localparam logic [4:0] EXP_RC_2 = 5'h09;
	localparam logic [4:0] EXP_RC_3 = 5'h05;

endpackage

//--- bench/wdg_props.sv
// Port checker of the watchdog guard.
// Assumes it is bound onto wdg_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module wdg_props
	import wdg_pkg::*;
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic ARST_N,
	// Register port
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	// Counting clocks and CPU side
	input wire logic RTC_CLK,
	input wire logic RC_OSC_CLK,
	input wire logic RC_OSC_ON,
	input wire logic EXT_NMI,
	input wire logic CPU_RST_REQ,
	input wire logic NMI_REQ,
	input wire logic IRQ
);
	logic en_q;
	logic en_d;
	logic en_w;
	logic [1:0] wclk;
	assign en_w = en_q & ~CPU_RST_REQ;
	assign en_d = en_w | (WR & (ADDR == ADDR_GUARD_CONTROL) & WDATA[CTL_EN_BIT]);
	assign wclk = WDATA[3:2];
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!ARST_N);
	// ----
	// Enable shadow
	// ----
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			en_q <= 1'b0;
		end else begin
			en_q <= en_d;
		end
	end
	sequence s_ctl_wr;
		WR && ADDR == ADDR_GUARD_CONTROL;
	endsequence
	chk_ctl_locked: assert property (s_ctl_wr ##0 en_w |=> $stable(RC_OSC_ON) || CPU_RST_REQ)
		else $error("control changed while locked");
	chk_clk_select: assert property (s_ctl_wr ##0 !en_w |=> RC_OSC_ON == ($past(wclk) == 2'b10))
		else $error("oscillator request wrong");
	chk_en_read: assert property (RD && ADDR == ADDR_GUARD_CONTROL |=> RDATA[7] == $past(en_w))
		else $error("enable bit read wrong");
	chk_restart_wo: assert property (RD && ADDR == ADDR_GUARD_RESTART |=> RDATA == 8'h00)
		else $error("restart register readable");
	chk_rst_pulse: assert property (CPU_RST_REQ |=> !CPU_RST_REQ)
		else $error("reset request too long");
	chk_nmi_pulse: assert property ($rose(NMI_REQ) |=> $fell(NMI_REQ))
		else $error("nmi request too long");
	chk_one_action: assert property (!(CPU_RST_REQ && NMI_REQ))
		else $error("reset and nmi together");
	chk_rst_clears: assert property (CPU_RST_REQ |-> RC_OSC_ON)
		else $error("control not cleared by time-out");
	chk_idle_quiet: assert property (!en_w |=> !CPU_RST_REQ && !NMI_REQ)
		else $error("time-out while disabled");
endmodule
`default_nettype wire

//--- bench/wdg_cpu_model.sv
// Far side model: real-time clock and RC oscillator sources.
// Assumes the oscillator request comes from the guard.
`timescale 1ns/10ps
`default_nettype none
module wdg_cpu_model #(
	parameter int HALF_NS = 100,
	parameter int WARM_NS = 400
) (
	// Oscillator request and clocks
	input wire logic rc_osc_on,
	output logic rtc_clk,
	output logic rc_osc_clk
);
	initial begin
		rtc_clk = 1'b0;
		forever #(HALF_NS + 3) rtc_clk = ~rtc_clk;
	end
	// Oscillator stopped unless requested
	always begin
		rc_osc_clk = 1'b0;
		wait (rc_osc_on === 1'b1);
		#(WARM_NS);
		while (rc_osc_on === 1'b1) #(HALF_NS) rc_osc_clk = ~rc_osc_clk;
	end
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench of the watchdog guard.
// Assumes wdg_top, wdg_props and wdg_cpu_model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; $display("wrong value at %0t: %0h expected %0h", $time, (g), (e)); end end
module testbench;
	import wdg_pkg::*;
	logic MCLK, ARST_N, WR, RD, EXT_NMI;
	logic [7:0] ADDR, WDATA, RDATA;
	logic RTC_CLK, RC_OSC_CLK, RC_OSC_ON, CPU_RST_REQ, NMI_REQ, IRQ;
	int failures = 0;
	int n_tests = 0;
	wdg_top dut (.MCLK(MCLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.RTC_CLK(RTC_CLK), .RC_OSC_CLK(RC_OSC_CLK), .RC_OSC_ON(RC_OSC_ON), .EXT_NMI(EXT_NMI),
		.CPU_RST_REQ(CPU_RST_REQ), .NMI_REQ(NMI_REQ), .IRQ(IRQ));
	wdg_cpu_model host (.rc_osc_on(RC_OSC_ON), .rtc_clk(RTC_CLK), .rc_osc_clk(RC_OSC_CLK));
	// ----
	// Bus tasks
	// ----
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge MCLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge MCLK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge MCLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge MCLK);
		RD <= 1'b0;
		#1;
		`CHK(RDATA, e)
	endtask
	task automatic chk_irq(input logic e);
		#1;
		`CHK(IRQ, e)
	endtask
	task automatic finish_test();
		if (failures == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Cycles until the chosen pulse, inside a window
	task automatic wait_evt(input logic nmi, input int lo, input int hi);
		int n;
		n = 0;
		do begin
			@(posedge MCLK);
			#1;
			n++;
		end while ((nmi ? NMI_REQ : CPU_RST_REQ) !== 1'b1 && n <= hi);
		`CHK(n >= lo && n <= hi, 1'b1)
		if (n > hi) finish_test();
	endtask
	initial begin
		MCLK = 1'b0;
		forever #5 MCLK = ~MCLK;
	end
	initial begin
		#300000;
		failures++;
		finish_test();
	end
	// ----
	// Main sequence
	// ----
	initial begin
		ARST_N = 1'b0;
		ADDR = 8'h00;
		WDATA = 8'h00;
		WR = 1'b0;
		RD = 1'b0;
		EXT_NMI = 1'b0;
		repeat (5) @(posedge MCLK);
		ARST_N <= 1'b1;
		rd(ADDR_GUARD_CONTROL, CTL_RESET);
		rd(ADDR_GUARD_RESTART, 8'h00);
		wr(ADDR_GUARD_CONTROL, 8'h3B);
		rd(ADDR_GUARD_CONTROL, 8'h0B);
		wr(ADDR_GUARD_CONTROL, 8'h8B);
		wr(ADDR_GUARD_CONTROL, 8'h40);
		rd(ADDR_GUARD_CONTROL, 8'h8B);
		wait_evt(1'b0, 560, 700);
		rd(ADDR_GUARD_CONTROL, 8'h28);
		wr(ADDR_IRQ_MASK, 8'h03);
		chk_irq(1'b1);
		wr(ADDR_IRQ_STATUS, 8'h01);
		chk_irq(1'b0);
		wr(ADDR_GUARD_CONTROL, 8'hC7);
		wait_evt(1'b1, 2540, 2720);
		rd(ADDR_GUARD_CONTROL, 8'hF7);
		repeat (2000) @(posedge MCLK);
		wr(ADDR_GUARD_RESTART, KEY_FIRST);
		repeat (50) @(posedge MCLK);
		wr(ADDR_GUARD_RESTART, KEY_SECOND);
		wait_evt(1'b1, 2540, 2720);
		wr(ADDR_IRQ_STATUS, 8'h07);
		chk_irq(1'b0);
		repeat (1800) @(posedge MCLK);
		wr(ADDR_GUARD_RESTART, KEY_FIRST);
		wr(ADDR_GUARD_RESTART, 8'h33);
		wr(ADDR_GUARD_RESTART, KEY_SECOND);
		chk_irq(1'b1);
		wait_evt(1'b1, 600, 1000);
		rd(ADDR_IRQ_STATUS, 8'h03);
		wr(ADDR_IRQ_STATUS, 8'h03);
		chk_irq(1'b0);
		@(posedge MCLK);
		EXT_NMI <= 1'b1;
		repeat (4) @(posedge MCLK);
		EXT_NMI <= 1'b0;
		repeat (6) @(posedge MCLK);
		rd(ADDR_GUARD_CONTROL, 8'hE7);
		rd(ADDR_IRQ_STATUS, 8'h04);
		ARST_N <= 1'b0;
		repeat (2) @(posedge MCLK);
		ARST_N <= 1'b1;
		rd(ADDR_GUARD_CONTROL, CTL_RESET);
		wr(ADDR_GUARD_CONTROL, 8'h83);
		repeat (1000) @(posedge MCLK);
		rd(ADDR_GUARD_CONTROL, 8'h83);
		finish_test();
	end
endmodule
bind wdg_top wdg_props u_props (.MCLK(MCLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .RTC_CLK(RTC_CLK), .RC_OSC_CLK(RC_OSC_CLK), .RC_OSC_ON(RC_OSC_ON), .EXT_NMI(EXT_NMI),
	.CPU_RST_REQ(CPU_RST_REQ), .NMI_REQ(NMI_REQ), .IRQ(IRQ));
`default_nettype wire
